// *** design/tal_pkg.sv ***
`default_nettype none
package tal_pkg;
  // register pointers
  localparam logic [7:0] PTR_CTRL = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // target address: fixed high nibble, low three bits from straps
  localparam logic [3:0] BUS_ADDR_BASE = 4'h3;
  // control word field positions
  localparam int HYST_LSB = 9;
  localparam int PWRDN_BIT = 8;
  localparam int CLOCK_BIT = 7;
  localparam int ALOCK_BIT = 6;
  localparam int CLEAR_BIT = 5;
  localparam int STS_BIT = 4;
  localparam int ENABLE_BIT = 3;
  localparam int CONLY_BIT = 2;
  localparam int POL_BIT = 1;
  localparam int MODE_BIT = 0;
  // reset values
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [12:0] TEMP_RESET = 13'h0000;
  // limit storage keeps the sign and 128 down to 0.25 degree weights
  localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
  // hysteresis in quarter-degree steps: 0, 1.5, 3, 6 degrees
  localparam logic signed [12:0] HYST_Q0 = 13'sh0000;
  localparam logic signed [12:0] HYST_Q1 = 13'sh0006;
  localparam logic signed [12:0] HYST_Q2 = 13'sh000C;
  localparam logic signed [12:0] HYST_Q3 = 13'sh0018;

  typedef struct packed {
    logic [1:0] hyst_sel;
    logic power_down_bit;
    logic critical_lock;
    logic alarm_lock;
    logic alarm_enable;
    logic critical_only_select;
    logic alarm_polarity;
    logic interrupt_mode;
  } tal_ctrl_s;

  localparam tal_ctrl_s CTRL_RESET = '0;

  typedef struct packed {
    logic scl;
    logic sda;
  } tal_link_s;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_PTR, PH_MSB, PH_LSB, PH_READ, PH_SKIP
  } tal_phase_e;
endpackage : tal_pkg
`default_nettype wire

// *** design/tal_thermal_alarm.sv ***
// How it works
// RULE_01: hysteresis code 00 none, 01 1.5, 10 3, 11 6 degrees, all limits.
// RULE_02: below flag sets under lower-hyst, clears at lower; above mirrors. Code: above sets over upper, clears at upper-hyst.
// RULE_03: power-down stops conversion, data updates and alarm events.
// RULE_04: power-down cannot be set while a lock is set; clear always works.
// RULE_05: bus keeps answering normally during power-down.
// RULE_06: critical lock freezes critical limit; only reset clears it.
// RULE_07: alarm lock freezes upper and lower limits; only reset clears it.
// RULE_08: clear write releases latched alarm; ignored in comparator mode.
// RULE_09: status bit reads one exactly while alarm is asserted.
// RULE_10: enable bit gates the alarm output; frozen under either lock.
// RULE_11: critical-only restricts alarm to critical; frozen under alarm lock.
// RULE_12: polarity zero asserts low, one asserts high.
// RULE_13: mode zero comparator, mode one latched interrupt.
// RULE_14: values are two's complement, sign bit 12, 0.25 degree steps.
// RULE_15: comparisons use bits 12 to 2; data reads keep finer bits.
// RULE_16: host writes bit 2 of limits zero at half-degree resolution.
// RULE_17: host writes unused and lowest bits of limits as zero.
// RULE_18: critical alarm holds until temperature reaches limit minus hyst.
// RULE_19: hysteresis field frozen while either lock is set.
// RULE_20: comparator follows condition; interrupt holds until cleared.
// RULE_21: locked writes are acknowledged but change nothing.
`default_nettype none
module tal_thermal_alarm (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire tal_pkg::tal_link_s link_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [2:0] addr_strap_i,
  input wire logic [12:0] sample_i,
  input wire logic sample_valid_i,
  output logic conv_run_o,
  output logic alarm_o,
  output logic alarm_oe_n
);
  import tal_pkg::*;

  // ==========================================================
  // functions
  function automatic logic signed [12:0] qdeg(input logic [15:0] v);
    qdeg = 13'($signed({{2{v[12]}}, v[12:2]}));
  endfunction : qdeg
  function automatic logic signed [12:0] hyst_amt(input logic [1:0] c);
    unique case (c)
      2'b00: hyst_amt = HYST_Q0;
      2'b01: hyst_amt = HYST_Q1;
      2'b10: hyst_amt = HYST_Q2;
      2'b11: hyst_amt = HYST_Q3;
    endcase
  endfunction : hyst_amt

  // ==========================================================
  // link sampling
  tal_link_s lk_s1_q, lk_s2_q, lk_s3_q;
  logic [2:0] strap_s1_q, strap_s2_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk_s1_q <= '1;
      lk_s2_q <= '1;
      lk_s3_q <= '1;
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      lk_s1_q <= link_i;
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
      strap_s1_q <= addr_strap_i;
      strap_s2_q <= strap_s1_q;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop, sda_in;
  assign sda_in = lk_s2_q.sda;
  assign scl_rise = lk_s2_q.scl & ~lk_s3_q.scl;
  assign scl_fall = ~lk_s2_q.scl & lk_s3_q.scl;
  assign bus_start = lk_s2_q.scl & lk_s3_q.scl & ~sda_in & lk_s3_q.sda;
  assign bus_stop = lk_s2_q.scl & lk_s3_q.scl & sda_in & ~lk_s3_q.sda;

  // ==========================================================
  // bus target
  tal_phase_e phase_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q, ptr_q, msb_q, tx_q;
  logic [15:0] rd_word_q, rdata, wr_data_q;
  logic ack_q, drive_q, rd_on_q, byte_sel_q, wr_stb_q;
  logic [7:0] rx_byte, tx_next;
  assign rx_byte = {shift_q[6:0], sda_in};
  assign tx_next = (!rd_on_q || byte_sel_q) ? rdata[15:8] : rd_word_q[7:0];
  // bus stays live in power-down; address match never looks at it
  always_ff @(posedge sys_clk or negedge arst_n) begin // see RULE_05
    if (!arst_n) begin
      phase_q <= PH_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= PTR_RESET;
      msb_q <= 8'h00;
      tx_q <= 8'h00;
      rd_word_q <= 16'h0000;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
      rd_on_q <= 1'b0;
      byte_sel_q <= 1'b0;
    end else if (bus_start) begin
      phase_q <= PH_ADDR;
      bitcnt_q <= 4'h0;
      drive_q <= 1'b0;
      rd_on_q <= 1'b0;
    end else if (bus_stop) begin
      phase_q <= PH_IDLE;
      drive_q <= 1'b0;
    end else if (phase_q != PH_IDLE && scl_rise) begin
      if (bitcnt_q < 4'd8) begin
        shift_q <= rx_byte;
        bitcnt_q <= bitcnt_q + 4'd1;
      end else begin
        bitcnt_q <= 4'd9;
        if (phase_q == PH_READ && sda_in) phase_q <= PH_SKIP;
      end
      if (bitcnt_q == 4'd7 && phase_q != PH_READ) begin
        ack_q <= 1'b1;
        unique case (phase_q)
          PH_ADDR: begin
            if (rx_byte[7:1] == {BUS_ADDR_BASE, strap_s2_q}) begin
              phase_q <= rx_byte[0] ? PH_READ : PH_PTR;
            end else begin
              phase_q <= PH_SKIP;
              ack_q <= 1'b0;
            end
          end
          PH_PTR: begin
            ptr_q <= rx_byte;
            phase_q <= PH_MSB;
          end
          PH_MSB: begin
            msb_q <= rx_byte;
            phase_q <= PH_LSB;
          end
          PH_LSB: phase_q <= PH_MSB;
          default: ack_q <= 1'b0;
        endcase
      end
    end else if (phase_q != PH_IDLE && scl_fall) begin
      if (bitcnt_q == 4'd8) begin
        drive_q <= (phase_q == PH_READ && rd_on_q) ? 1'b0 : ack_q;
      end else if (bitcnt_q == 4'd9) begin
        bitcnt_q <= 4'h0;
        if (phase_q == PH_READ) begin
          if (!rd_on_q || byte_sel_q) rd_word_q <= rdata;
          byte_sel_q <= rd_on_q & ~byte_sel_q;
          rd_on_q <= 1'b1;
          tx_q <= {tx_next[6:0], 1'b0};
          drive_q <= ~tx_next[7];
        end else begin
          drive_q <= 1'b0;
        end
      end else if (phase_q == PH_READ && rd_on_q) begin
        tx_q <= {tx_q[6:0], 1'b0};
        drive_q <= ~tx_q[7];
      end
    end
  end
  // word commit after the low byte
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_stb_q <= 1'b0;
      wr_data_q <= 16'h0000;
    end else begin
      wr_stb_q <= scl_rise && bitcnt_q == 4'd7 && phase_q == PH_LSB;
      if (scl_rise && bitcnt_q == 4'd7 && phase_q == PH_LSB) begin
        wr_data_q <= {msb_q, rx_byte};
      end
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive_q;

  // ==========================================================
  // control and limits
  tal_ctrl_s ctrl_q;
  logic [15:0] upper_alarm_threshold_q, lower_alarm_threshold_q;
  logic [15:0] critical_threshold_q;
  logic [12:0] temp_data_q;
  logic lock_any, ctrl_wr, clr_pulse, alarm_asserted_flag;
  assign lock_any = ctrl_q.critical_lock | ctrl_q.alarm_lock;
  assign ctrl_wr = wr_stb_q && ptr_q == PTR_CTRL;
  // clear acts only in interrupt mode and is never stored
  assign clr_pulse = ctrl_wr & wr_data_q[CLEAR_BIT]
                     & ctrl_q.interrupt_mode; // see RULE_08
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      if (wr_data_q[CLOCK_BIT]) ctrl_q.critical_lock <= 1'b1; // see RULE_06
      if (wr_data_q[ALOCK_BIT]) ctrl_q.alarm_lock <= 1'b1; // see RULE_07
      if (!wr_data_q[PWRDN_BIT]) begin
        ctrl_q.power_down_bit <= 1'b0;
      end else if (!lock_any) begin
        ctrl_q.power_down_bit <= 1'b1; // see RULE_04
      end
      if (!lock_any) begin
        ctrl_q.hyst_sel <= wr_data_q[HYST_LSB +: 2]; // see RULE_19
        ctrl_q.alarm_enable <= wr_data_q[ENABLE_BIT]; // see RULE_10
      end
      if (!ctrl_q.alarm_lock) begin
        ctrl_q.critical_only_select <= wr_data_q[CONLY_BIT]; // see RULE_11
      end
      ctrl_q.alarm_polarity <= wr_data_q[POL_BIT];
      ctrl_q.interrupt_mode <= wr_data_q[MODE_BIT];
    end
  end
  // locked writes were acknowledged on the bus and are dropped here
  always_ff @(posedge sys_clk or negedge arst_n) begin // see RULE_21
    if (!arst_n) begin
      upper_alarm_threshold_q <= LIMIT_RESET;
      lower_alarm_threshold_q <= LIMIT_RESET;
      critical_threshold_q <= LIMIT_RESET;
    end else if (wr_stb_q) begin
      if (ptr_q == PTR_UPPER && !ctrl_q.alarm_lock) begin
        upper_alarm_threshold_q <= wr_data_q & LIMIT_MASK; // see RULE_07
      end
      if (ptr_q == PTR_LOWER && !ctrl_q.alarm_lock) begin
        lower_alarm_threshold_q <= wr_data_q & LIMIT_MASK; // see RULE_07
      end
      if (ptr_q == PTR_CRIT && !ctrl_q.critical_lock) begin
        critical_threshold_q <= wr_data_q & LIMIT_MASK; // see RULE_06
      end
    end
  end
  always_comb begin
    unique case (ptr_q)
      PTR_CTRL: begin
        rdata = 16'h0000;
        rdata[HYST_LSB +: 2] = ctrl_q.hyst_sel;
        rdata[PWRDN_BIT] = ctrl_q.power_down_bit;
        rdata[CLOCK_BIT] = ctrl_q.critical_lock;
        rdata[ALOCK_BIT] = ctrl_q.alarm_lock;
        rdata[STS_BIT] = alarm_asserted_flag; // see RULE_09
        rdata[ENABLE_BIT] = ctrl_q.alarm_enable;
        rdata[CONLY_BIT] = ctrl_q.critical_only_select;
        rdata[POL_BIT] = ctrl_q.alarm_polarity;
        rdata[MODE_BIT] = ctrl_q.interrupt_mode;
      end
      PTR_UPPER: rdata = upper_alarm_threshold_q;
      PTR_LOWER: rdata = lower_alarm_threshold_q;
      PTR_CRIT: rdata = critical_threshold_q;
      PTR_TEMP: rdata = {3'h0, temp_data_q}; // see RULE_15
      default: rdata = 16'h0000;
    endcase
  end

  // ==========================================================
  // limit comparison
  logic above_q, below_q, crit_q, cond, cond_prev_q, latch_q, take;
  logic signed [12:0] t_q, hy, up_l, lo_l, cr_l;
  assign conv_run_o = ~ctrl_q.power_down_bit; // see RULE_03
  assign take = sample_valid_i & ~ctrl_q.power_down_bit; // see RULE_03
  // two's complement, sign at 12, 0.25 degree lsb at 2
  assign t_q = qdeg({3'h0, sample_i}); // see RULE_14, RULE_15
  assign up_l = qdeg(upper_alarm_threshold_q);
  assign lo_l = qdeg(lower_alarm_threshold_q);
  assign cr_l = qdeg(critical_threshold_q);
  assign hy = hyst_amt(ctrl_q.hyst_sel); // see RULE_01
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_data_q <= TEMP_RESET;
      above_q <= 1'b0;
      below_q <= 1'b0;
      crit_q <= 1'b0;
    end else if (take) begin
      temp_data_q <= sample_i;
      above_q <= above_q ? (t_q > up_l - hy) : (t_q > up_l); // see RULE_02
      below_q <= below_q ? (t_q < lo_l) : (t_q < lo_l - hy); // see RULE_02
      crit_q <= crit_q ? (t_q > cr_l - hy) : (t_q > cr_l); // see RULE_18
    end
  end

  // ==========================================================
  // alarm output
  assign cond = crit_q
                | (~ctrl_q.critical_only_select
                   & (above_q | below_q)); // see RULE_11
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_prev_q <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      cond_prev_q <= cond;
      // a new condition wins over a clear in the same cycle
      if (cond & ~cond_prev_q & ~ctrl_q.power_down_bit) begin
        latch_q <= 1'b1; // see RULE_20
      end else if (clr_pulse) begin
        latch_q <= 1'b0; // see RULE_08
      end
    end
  end
  assign alarm_asserted_flag = ctrl_q.alarm_enable
                               & (ctrl_q.interrupt_mode ? latch_q
                                  : cond); // see RULE_10, RULE_13
  logic alarm_level_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) alarm_level_q <= 1'b1;
    else alarm_level_q <= alarm_asserted_flag ~^ ctrl_q.alarm_polarity; // see RULE_12
  end
  assign alarm_o = 1'b0;
  assign alarm_oe_n = alarm_level_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence clear_req;
    clr_pulse && !(cond && !cond_prev_q);
  endsequence
  sequence locked_pd_try;
    ctrl_wr && lock_any && wr_data_q[PWRDN_BIT] && !ctrl_q.power_down_bit;
  endsequence
  crit_lock_sticky_a: assert property (ctrl_q.critical_lock |=> ctrl_q.critical_lock) // see RULE_06
    else $error("critical lock dropped");
  crit_limit_frozen_a: assert property (ctrl_q.critical_lock |=> $stable(critical_threshold_q)) // see RULE_06
    else $error("critical limit changed while locked");
  window_frozen_a: assert property (ctrl_q.alarm_lock |=> $stable(upper_alarm_threshold_q) && $stable(lower_alarm_threshold_q)) // see RULE_07
    else $error("window limits changed while locked");
  pd_refused_a: assert property (locked_pd_try |=> !ctrl_q.power_down_bit) // see RULE_04
    else $error("power-down set under lock");
  hyst_frozen_a: assert property (lock_any |=> $stable(ctrl_q.hyst_sel) && $stable(ctrl_q.alarm_enable)) // see RULE_19
    else $error("hysteresis or enable changed under lock");
  clear_release_a: assert property (clear_req |=> !latch_q) // see RULE_08
    else $error("clear did not release alarm");
  enable_gate_a: assert property (!ctrl_q.alarm_enable |=> alarm_oe_n == !$past(ctrl_q.alarm_polarity)) // see RULE_10
    else $error("alarm asserted while disabled");
  comp_follow_a: assert property (!ctrl_q.interrupt_mode && ctrl_q.alarm_enable |=> alarm_oe_n == ($past(cond) ~^ $past(ctrl_q.alarm_polarity))) // see RULE_20
    else $error("comparator output not following condition");
  pd_freeze_a: assert property (ctrl_q.power_down_bit |=> $stable(temp_data_q) && $stable(crit_q)) // see RULE_03
    else $error("data updated in power-down");
  crit_only_a: assert property (ctrl_q.critical_only_select && !crit_q && !ctrl_q.interrupt_mode |-> !alarm_asserted_flag) // see RULE_11
    else $error("window alarm in critical-only mode");
endmodule : tal_thermal_alarm
`default_nettype wire

// *** testbench/tal_host_model.sv ***
`default_nettype none
// ==========
// two-wire host, scl stands high between frames
module tal_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_w
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // data changes only while scl is low
  task automatic put_bit(input logic b);
    sda_drv = b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 b = sda_w;
    #40 scl = 1'b0;
    #40;
  endtask : get_bit
  task automatic start;
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask : start
  task automatic stop;
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #80;
  endtask : stop
  task automatic put_byte(input logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(nak);
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(last);
  endtask : get_byte
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [15:0] w, output logic nak);
    logic k0, k1, k2, k3;
    start;
    put_byte({a, 1'b0}, k0);
    put_byte(p, k1);
    put_byte(w[15:8], k2);
    put_byte(w[7:0], k3);
    stop;
    nak = k0 | k1 | k2 | k3;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [15:0] w, output logic nak);
    logic k0, k1, k2;
    start;
    put_byte({a, 1'b0}, k0);
    put_byte(p, k1);
    start;
    put_byte({a, 1'b1}, k2);
    get_byte(1'b0, w[15:8]);
    get_byte(1'b1, w[7:0]);
    stop;
    nak = k0 | k1 | k2;
  endtask : rd
endmodule : tal_host_model
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tal_pkg::*;
  logic sys_clk, arst_n, sample_valid, nak, pol, scl, sda_drv;
  logic sda_o, sda_oe_n, conv_run_o, alarm_o, alarm_oe_n;
  logic [2:0] strap;
  logic [12:0] sample;
  logic [6:0] dev;
  logic [15:0] rv, w;
  tal_link_s link;
  int seed = 93815;
  int mismatches = 0;
  int checks_done = 0;
  // open drain with pull-up
  assign link.scl = scl;
  assign link.sda = sda_drv & (sda_oe_n | sda_o);
  tal_thermal_alarm tal_thermal_alarm_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .link_i(link), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_strap_i(strap), .sample_i(sample),
    .sample_valid_i(sample_valid), .conv_run_o(conv_run_o),
    .alarm_o(alarm_o), .alarm_oe_n(alarm_oe_n));
  tal_host_model tal_host_model_i (
    .scl(scl), .sda_drv(sda_drv), .sda_w(link.sda));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========
  // helpers
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  function automatic logic [15:0] cw(input logic [1:0] h,
                                     input logic [3:0] f);
    return {5'h00, h, 5'h00, f};
  endfunction : cw
  function automatic logic [15:0] lim(input logic signed [10:0] q);
    return {3'h0, q, 2'h0};
  endfunction : lim
  function automatic logic signed [10:0] hq(input logic [1:0] h);
    return (h == 2'h0) ? 11'sh000 : 11'(6 << (h - 1));
  endfunction : hq
  task automatic wrc(input logic [7:0] p, input logic [15:0] v);
    tal_host_model_i.wr(dev, p, v, nak);
    check("ack", 16'(nak), 16'h0000);
  endtask : wrc
  task automatic rdc(input logic [7:0] p, input logic [15:0] e);
    tal_host_model_i.rd(dev, p, rv, nak);
    check("read", rv, e);
  endtask : rdc
  task automatic feed(input logic signed [10:0] q, input logic [1:0] f);
    @(negedge sys_clk);
    sample = {q, f};
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : feed
  task automatic pinc(input logic a);
    logic lvl;
    // asserted shows the polarity level, idle its inverse
    lvl = a ~^ pol;
    check("pin", 16'(alarm_oe_n), 16'(lvl));
  endtask : pinc
  // ==========
  // tests
  initial begin
    arst_n = 1'b0;
    sample = 13'h0000;
    sample_valid = 1'b0;
    pol = 1'b0;
    strap = 3'($random(seed));
    dev = {BUS_ADDR_BASE, strap};
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("run", 16'(conv_run_o), 16'h0001);
    pinc(1'b0);
    for (int p = 1; p <= 4; p++) rdc(8'(p), 16'h0000);
    for (int p = 2; p <= 4; p++) begin
      w = 16'($random(seed)) & 16'h1FFC;
      wrc(8'(p), w);
      rdc(8'(p), w);
    end
    $display("done reset and limits");
    wrc(PTR_UPPER, lim(11'sd40));
    wrc(PTR_LOWER, lim(-11'sd40));
    wrc(PTR_CRIT, lim(11'sd400));
    for (int h = 0; h < 4; h++) begin
      pol = h[0];
      wrc(PTR_CTRL, cw(2'(h), {2'b10, pol, 1'b0}));
      feed(11'sd40, 2'($random(seed)));
      pinc(1'b0);
      feed(11'sd41, 2'h0);
      pinc(1'b1);
      rdc(PTR_CTRL, cw(2'(h), {2'b10, pol, 1'b0}) | 16'h0010);
      wrc(PTR_CTRL, cw(2'(h), {2'b10, pol, 1'b0}) | 16'h0020);
      pinc(1'b1);
      feed(11'sd41 - hq(2'(h)), 2'h3);
      pinc(1'b1);
      feed(11'sd40 - hq(2'(h)), 2'h0);
      pinc(1'b0);
    end
    feed(-11'sd65, 2'h0);
    pinc(1'b1);
    feed(-11'sd41, 2'h0);
    pinc(1'b1);
    feed(-11'sd40, 2'h0);
    pinc(1'b0);
    $display("done comparator");
    pol = 1'b0;
    wrc(PTR_CTRL, cw(2'h0, 4'b1001));
    feed(11'sd41, 2'h0);
    feed(11'sd0, 2'h0);
    pinc(1'b1);
    wrc(PTR_CTRL, cw(2'h0, 4'b1001) | 16'h0020);
    pinc(1'b0);
    rdc(PTR_CTRL, cw(2'h0, 4'b1001));
    wrc(PTR_CTRL, cw(2'h1, 4'b1100));
    feed(11'sd41, 2'h0);
    pinc(1'b0);
    feed(11'sd401, 2'h0);
    pinc(1'b1);
    feed(11'sd395, 2'h0);
    pinc(1'b1);
    feed(11'sd394, 2'h0);
    pinc(1'b0);
    wrc(PTR_CTRL, cw(2'h0, 4'b0000));
    feed(11'sd401, 2'h0);
    pinc(1'b0);
    $display("done interrupt and critical");
    feed(11'sd0, 2'h1);
    wrc(PTR_CTRL, cw(2'h0, 4'b1000) | 16'h0100);
    check("run", 16'(conv_run_o), 16'h0000);
    feed(11'sd401, 2'h0);
    pinc(1'b0);
    rdc(PTR_TEMP, 16'h0001);
    wrc(PTR_CTRL, cw(2'h0, 4'b1000));
    check("run", 16'(conv_run_o), 16'h0001);
    wrc(PTR_CTRL, cw(2'h0, 4'b1000) | 16'h0040);
    wrc(PTR_UPPER, lim(11'sd100));
    rdc(PTR_UPPER, lim(11'sd40));
    wrc(PTR_CRIT, lim(11'sd300));
    rdc(PTR_CRIT, lim(11'sd300));
    wrc(PTR_CTRL, cw(2'h3, 4'b0100) | 16'h0100);
    rdc(PTR_CTRL, 16'h0048);
    wrc(PTR_CTRL, 16'h00C8);
    wrc(PTR_CRIT, lim(11'sd5));
    rdc(PTR_CRIT, lim(11'sd300));
    @(negedge sys_clk);
    arst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rdc(PTR_CTRL, 16'h0000);
    $display("done power-down and locks");
    stop_test;
  end
  initial begin
    #900000;
    mismatches++;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
